// ### design/rxdsk_pkg.sv
// Purpose: shared constants and types of the receive lane phase deskew controller
// Assumes: hclk at 100 MHz; AHB-Lite register window of 32-bit words
// Notes: offsets are byte addresses inside the slave's window
`default_nettype none

package rxdsk_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;   // hclk period
  localparam int SETTLE_NS = 200;      // least wait after a step before sampling lanes
  // least time, so round up to whole cycles
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // phase stepping
  // ----------------------------------------------------------------
  localparam int STEPS_PER_VCO = 56;            // one step is 1/56 of the VCO period
  localparam int SHIFT_COUNT_DEF = STEPS_PER_VCO; // total steps of one sweep
  localparam int POS_W = 8;                     // width of phase positions and counts
  localparam logic [POS_W-1:0] GUARD_RST = 8'h08; // early-side guard after reset
  localparam logic PS_INC = 1'b1;               // direction code for a later phase

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GUARD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_STEPS = 8'h10;
  localparam int CTRL_EN_BIT = 0;       // enable of the search
  localparam int CTRL_RESTART_BIT = 1;  // write one: start a new pass
  localparam int CTRL_FIFO_BIT = 2;     // write one: one-cycle buffer reset
  localparam int ST_STATE_LSB = 0;      // three bits of state
  localparam int ST_DONE_BIT = 4;
  localparam int ST_NOWIN_BIT = 5;
  localparam int ST_LOCK_BIT = 6;
  localparam int ST_ALLDONE_BIT = 7;
  localparam int RES_START_LSB = 0;
  localparam int RES_LEN_LSB = 8;
  localparam int RES_TGT_LSB = 16;
  localparam int STATE_W = 3;

  // ----------------------------------------------------------------
  // bus codes
  // ----------------------------------------------------------------
  localparam int HTRANS_ACT_BIT = 1;    // set for NONSEQ and SEQ
  localparam logic HRESP_OKAY = 1'b0;

  // controller states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETTLE = 3'b001,
    S_WAIT = 3'b010,
    S_AIM = 3'b011,
    S_MOVE = 3'b100,
    S_DONE = 3'b101
  } rxdsk_state_t;

endpackage

`default_nettype wire

// ### design/rxdsk_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: output changes only once stages two and three agree
`default_nettype none

module rxdsk_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // asynchronous levels in, filtered levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;  // first stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;   // accepted level
  } rxdsk_sync_t;

  rxdsk_sync_t r;
  rxdsk_sync_t n;
  logic [W-1:0] agree;  // stages two and three match

  // next state: shift and accept agreed bits
  always_comb begin
    n = r;
    agree = ~(r.s2 ^ r.s3);
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q = (agree & r.s3) | (~agree & r.q);
  end

  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.q;

endmodule // rxdsk_sync

`default_nettype wire

// ### design/rxdsk_ctrl.sv
// Purpose: receive lane phase deskew controller driving a phase-shifting clock generator
// Assumes: one clock generator phase-shift port on hclk; lane status arrives asynchronously
// Notes: sweeps one full VCO period, then settles on the best eye position
`default_nettype none

module rxdsk_ctrl
  import rxdsk_pkg::*;
#(
  parameter int LANES = 4,
  parameter int SHIFT_COUNT = SHIFT_COUNT_DEF,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // receive channels
  input wire logic [LANES-1:0] rx_reset_done,
  input wire logic [LANES-1:0] rx_lane_ok,
  output logic rx_elastic_buffer_reset,
  // user logic
  input wire logic user_fifo_reset,
  // phase-shifting clock generator
  input wire logic psgen_locked,
  input wire logic psgen_done,
  output logic psgen_en,
  output logic psgen_incdec
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rxdsk_state_t st;               // controller state
    logic en;                       // search enable
    logic restart;                  // restart held while a step is in flight
    logic aiming;                   // steps now go to the target, not the sweep
    logic [POS_W-1:0] guard;        // early-side guard in steps
    logic all_prev;                 // last all-lanes reset-done level
    logic [POS_W-1:0] idx;          // sweep position
    logic [POS_W-1:0] settle;       // settle counter
    logic [POS_W-1:0] run_start;    // start of current good run
    logic [POS_W-1:0] run_len;      // length of current good run
    logic [POS_W-1:0] best_start;   // start of longest good run
    logic [POS_W-1:0] best_len;     // length of longest good run
    logic [POS_W-1:0] target;       // final offset from origin
    logic [POS_W-1:0] moved;        // steps taken toward target
    logic nowin;                    // sweep found no good position
    logic done;                     // pass finished
    logic ps_en;                    // one-cycle step request
    logic fifo_pulse;               // software buffer reset pulse
    logic fifo_rst;                 // buffer reset to channels
    logic wr_pend;                  // write data phase pending
    logic [7:0] wr_addr;            // address of pending write
    logic [31:0] rdata;             // read data for the data phase
  } rxdsk_regs_t;

  localparam rxdsk_regs_t R_RST = '{st: S_IDLE, en: 1'b1, guard: GUARD_RST, default: '0};

  rxdsk_regs_t r;
  rxdsk_regs_t n;
  logic [2*LANES:0] sq;             // synchronised pin levels
  logic all_done;                   // every lane reports reset done
  logic lanes_ok;                   // every lane sees good data
  logic locked;                     // clock generator locked
  logic rise;                       // low-to-high of all_done
  logic aphase;                     // address phase taken
  logic sw_restart;                 // software asked for a new pass
  logic kick;                       // any cause of a new pass
  logic abort;                      // pass must stop now
  logic [POS_W-1:0] half;           // half of best run
  logic [POS_W-1:0] aim_off;        // chosen offset inside best run
  logic [POS_W-1:0] run_nxt;        // run length after a good sample
  logic [31:0] rd_word;             // read mux

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  rxdsk_sync #(
    .W(2 * LANES + 1)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({psgen_locked, rx_lane_ok, rx_reset_done}),
    .q(sq)
  );

  assign all_done = &sq[LANES-1:0];
  assign lanes_ok = &sq[2*LANES-1:LANES];
  assign locked = sq[2*LANES];
  assign rise = all_done && !r.all_prev;
  assign aphase = hsel && hready && htrans[HTRANS_ACT_BIT];
  assign sw_restart = r.wr_pend && (r.wr_addr == OFS_CTRL) && hwdata[CTRL_RESTART_BIT];
  assign kick = r.restart || rise || sw_restart;
  // losing lane status or lock stops a pass; a fresh edge starts a new one
  assign abort = !all_done || !locked || !r.en || kick;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    rd_word = '0;
    half = r.best_len >> 1;
    aim_off = (r.guard < half) ? r.guard : half;
    run_nxt = r.run_len + POS_W'(1);
    n.ps_en = 1'b0;
    n.fifo_pulse = 1'b0;
    n.all_prev = all_done;
    // edge is held until the in-flight step is answered
    if (rise || sw_restart) begin
      n.restart = 1'b1;
    end

    // register writes land in the data phase
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        OFS_CTRL: begin
          n.en = hwdata[CTRL_EN_BIT];
          n.fifo_pulse = hwdata[CTRL_FIFO_BIT];
        end
        OFS_GUARD: begin
          n.guard = hwdata[POS_W-1:0];
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
    n.wr_pend = aphase && hwrite;
    if (aphase) begin
      n.wr_addr = haddr[7:0];
    end

    // read mux, sampled in the address phase so data stands from a flop
    unique case (haddr[7:0])
      OFS_CTRL: begin
        rd_word[CTRL_EN_BIT] = r.en;
      end
      OFS_GUARD: begin
        rd_word[POS_W-1:0] = r.guard;
      end
      OFS_STATUS: begin
        rd_word[ST_STATE_LSB +: STATE_W] = r.st;
        rd_word[ST_DONE_BIT] = r.done;
        rd_word[ST_NOWIN_BIT] = r.nowin;
        rd_word[ST_LOCK_BIT] = locked;
        rd_word[ST_ALLDONE_BIT] = all_done;
      end
      OFS_RESULT: begin
        rd_word[RES_START_LSB +: POS_W] = r.best_start;
        rd_word[RES_LEN_LSB +: POS_W] = r.best_len;
        rd_word[RES_TGT_LSB +: POS_W] = r.target;
      end
      OFS_STEPS: begin
        rd_word[POS_W-1:0] = POS_W'(SHIFT_COUNT);
      end
      default: begin
        rd_word = '0;  // unmapped reads as zero
      end
    endcase
    if (aphase && !hwrite) begin
      n.rdata = rd_word;
    end

    // user and software buffer reset reach the channels one cycle later
    n.fifo_rst = user_fifo_reset || r.fifo_pulse;

    // deskew state machine
    unique case (r.st)
      S_IDLE: begin
        // hold off until all channels report reset done and the clock is locked
        if (r.en && all_done && locked) begin
          n.st = S_SETTLE;
          n.restart = 1'b0;
          n.aiming = 1'b0;
          n.done = 1'b0;
          n.nowin = 1'b0;
          n.idx = '0;
          n.settle = '0;
          n.run_len = '0;
          n.best_len = '0;
          n.best_start = '0;
          n.target = '0;
          n.moved = '0;
        end
      end
      S_SETTLE: begin
        if (abort) begin
          n.st = S_IDLE;
          n.restart = 1'b0;
        end else if (r.settle == POS_W'(SETTLE_CYCLES - 1)) begin
          // sample the lanes at this phase and track the longest good run
          n.settle = '0;
          if (lanes_ok) begin
            n.run_len = run_nxt;
            if (r.run_len == '0) begin
              n.run_start = r.idx;
            end
            if (run_nxt > r.best_len) begin
              n.best_len = run_nxt;
              n.best_start = (r.run_len == '0) ? r.idx : r.run_start;
            end
          end else begin
            n.run_len = '0;
          end
          n.ps_en = 1'b1;
          n.st = S_WAIT;
        end else begin
          n.settle = r.settle + POS_W'(1);
        end
      end
      S_WAIT: begin
        // no new request until the generator answers the last one
        if (psgen_done) begin
          if (kick || !all_done || !locked || !r.en) begin
            n.st = S_IDLE;
            n.restart = 1'b0;
          end else if (r.aiming) begin
            n.moved = r.moved + POS_W'(1);
            n.st = (r.moved + POS_W'(1) == r.target) ? S_DONE : S_MOVE;
            n.done = (r.moved + POS_W'(1) == r.target);
          end else begin
            // a full sweep of 1/56 steps brings the clock back to its origin
            n.idx = r.idx + POS_W'(1);
            n.st = (r.idx + POS_W'(1) == POS_W'(SHIFT_COUNT)) ? S_AIM : S_SETTLE;
          end
        end
      end
      S_AIM: begin
        // sit just inside the early edge: most late margin, bounded early loss.
        // a good run that wraps past the origin is seen as two runs
        if (abort) begin
          n.st = S_IDLE;
          n.restart = 1'b0;
        end else begin
          n.aiming = 1'b1;
          n.moved = '0;
          n.nowin = (r.best_len == '0);
          n.target = (r.best_len == '0) ? '0 : r.best_start + aim_off;
          n.done = (r.best_len == '0) || (r.best_start + aim_off == '0);
          n.st = n.done ? S_DONE : S_MOVE;
        end
      end
      S_MOVE: begin
        if (abort) begin
          n.st = S_IDLE;
          n.restart = 1'b0;
        end else begin
          n.ps_en = 1'b1;
          n.st = S_WAIT;
        end
      end
      S_DONE: begin
        // result holds until a new edge or lost status
        if (abort) begin
          n.st = S_IDLE;
          n.restart = 1'b0;
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= R_RST;
    end else begin
      r <= n;
    end
  end

  // outputs: zero-wait slave, always OKAY
  assign hrdata = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign psgen_en = r.ps_en;
  assign psgen_incdec = PS_INC;
  assign rx_elastic_buffer_reset = r.fifo_rst;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_step_then_wait;
    psgen_en |=> (r.st == S_WAIT) && !psgen_en;
  endproperty
  a_step_then_wait: assert property (p_step_then_wait) else $error("step not followed by wait");

  property p_quiet_wait;
    (r.st == S_WAIT) && ($past(r.st) == S_WAIT) |-> !psgen_en;
  endproperty
  a_quiet_wait: assert property (p_quiet_wait) else $error("step issued while waiting");

  property p_hold_off;
    psgen_en |-> $past(all_done) && $past(locked);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("step without all lanes done");

  property p_edge_restart;
    rise && (r.st inside {S_SETTLE, S_AIM, S_MOVE, S_DONE}) |=> r.st == S_IDLE;
  endproperty
  a_edge_restart: assert property (p_edge_restart) else $error("edge did not restart");

  property p_retrain_restart;
    (r.st == S_WAIT) && psgen_done && (r.restart || rise) |=> (r.st == S_IDLE) ##1 !r.done;
  endproperty
  a_retrain_restart: assert property (p_retrain_restart) else $error("held edge lost");

  property p_sweep_len;
    (r.st == S_AIM) |-> (r.idx == POS_W'(SHIFT_COUNT)) && !r.aiming;
  endproperty
  a_sweep_len: assert property (p_sweep_len) else $error("sweep length wrong");

  property p_aim_window;
    (r.st == S_AIM) && (r.best_len != '0) && !abort |=>
      (r.target >= r.best_start) && (r.target - r.best_start <= r.guard) &&
      (r.target - r.best_start <= (r.best_len >> 1));
  endproperty
  a_aim_window: assert property (p_aim_window) else $error("target outside window");

  property p_reach_target;
    (r.st == S_DONE) |-> (r.moved == r.target) && r.done;
  endproperty
  a_reach_target: assert property (p_reach_target) else $error("done before target");

  property p_fifo_follow;
    user_fifo_reset |=> rx_elastic_buffer_reset;
  endproperty
  a_fifo_follow: assert property (p_fifo_follow) else $error("buffer reset not passed");

endmodule // rxdsk_ctrl

`default_nettype wire

// ### tb/rxdsk_partner.sv
// Purpose: model of the phase-shifting clock generator and the receive lanes
// Assumes: one step request at a time; lanes share one eye window
// Notes: lock comes eleven cycles after reset; step answers may be slow
`default_nettype none

module rxdsk_partner
  import rxdsk_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // phase-shift port
  input wire logic psgen_en,
  input wire logic psgen_incdec,
  output logic psgen_locked,
  output logic psgen_done,
  // lanes
  output logic [3:0] rx_lane_ok,
  // bench control and view
  input wire logic [7:0] win_lo,
  input wire logic [7:0] win_len,
  input wire logic slow,
  output logic [7:0] phase,
  output logic [15:0] step_cnt,
  output logic ovl_err
);
  timeunit 1ns;
  timeprecision 1ns;

  int seed = 85206; // fixed seed for answer delays
  int lock_cnt; // cycles since reset
  int wait_c; // cycles left before the answer
  logic pend; // a step is outstanding
  logic good; // read clock inside the eye

  // ----------------------------------------------------------------
  // step handling
  // ----------------------------------------------------------------
  // a request while one is pending is flagged, never answered twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt <= 0;
      psgen_locked <= 1'b0;
      psgen_done <= 1'b0;
      pend <= 1'b0;
      wait_c <= 0;
      phase <= 8'h00;
      step_cnt <= 16'h0000;
      ovl_err <= 1'b0;
    end else begin
      psgen_done <= 1'b0;
      if (lock_cnt < 10) begin
        lock_cnt <= lock_cnt + 1;
      end
      psgen_locked <= (lock_cnt >= 10);
      if (psgen_en) begin
        if (pend) begin
          ovl_err <= 1'b1;
        end
        pend <= 1'b1;
        step_cnt <= step_cnt + 16'h0001;
        wait_c <= slow ? int'($unsigned($random(seed)) % 30) : 0;
      end else if (pend) begin
        if (wait_c == 0) begin
          pend <= 1'b0;
          psgen_done <= 1'b1;
          // one step is one fifty-sixth of the vco period
          if (psgen_incdec) begin
            phase <= (phase == 8'(STEPS_PER_VCO - 1)) ? 8'h00 : phase + 8'h01;
          end else begin
            phase <= (phase == 8'h00) ? 8'(STEPS_PER_VCO - 1) : phase - 8'h01;
          end
        end else begin
          wait_c <= wait_c - 1;
        end
      end
    end
  end

  // lanes are good only while the phase lies in the eye window
  always_comb begin
    good = ((int'(phase) + STEPS_PER_VCO - int'(win_lo)) % STEPS_PER_VCO) < int'(win_len);
    rx_lane_ok = {4{good}};
  end
endmodule // rxdsk_partner

`default_nettype wire

// ### tb/rx_lane_phase_deskew_fsm_test.sv
// Purpose: self-checking bench of the deskew controller
// Assumes: zero-wait slave; partner model on the phase-shift side
// Notes: every pass is predicted by a scan of the eye window
`default_nettype none

module rx_lane_phase_deskew_fsm_test
  import rxdsk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [3:0] rx_reset_done = 4'h0;
  logic [3:0] rx_lane_ok;
  logic rx_elastic_buffer_reset;
  logic user_fifo_reset = 1'b0;
  logic psgen_locked, psgen_done, psgen_en, psgen_incdec;
  logic [7:0] win_lo = 8'h00;
  logic [7:0] win_len = 8'h00;
  logic slow = 1'b0;
  logic [7:0] phase;
  logic [15:0] step_cnt;
  logic ovl_err;
  logic [31:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 85206;
  int n;

  rxdsk_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_reset_done(rx_reset_done),
    .rx_lane_ok(rx_lane_ok), .rx_elastic_buffer_reset(rx_elastic_buffer_reset),
    .user_fifo_reset(user_fifo_reset), .psgen_locked(psgen_locked),
    .psgen_done(psgen_done), .psgen_en(psgen_en), .psgen_incdec(psgen_incdec));

  rxdsk_partner far (.hclk(hclk), .hresetn(hresetn), .psgen_en(psgen_en),
    .psgen_incdec(psgen_incdec), .psgen_locked(psgen_locked), .psgen_done(psgen_done),
    .rx_lane_ok(rx_lane_ok), .win_lo(win_lo), .win_len(win_len), .slow(slow),
    .phase(phase), .step_cnt(step_cnt), .ovl_err(ovl_err));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wrap_up;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h, want %0h", $time, seen, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq);
    int k;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    rq = hrdata;
    if (k >= 100) begin n_errors++; wrap_up(); end
  endtask

  // trailing idle so a following read sees the new value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    xfer(1'b1, a, d, rq);
    @(posedge hclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    xfer(1'b0, a, 32'h0, rq);
  endtask

  // reference: longest non-wrapping run of good samples from the pass origin
  task automatic model(input int p0, lo, len, g, output int bs, bl, tgt);
    int run;
    bs = 0;
    bl = 0;
    run = 0;
    for (int i = 0; i < SHIFT_COUNT_DEF; i++) begin
      if (((p0 + i - lo + 2 * STEPS_PER_VCO) % STEPS_PER_VCO) < len) begin
        run++;
        if (run > bl) begin bl = run; bs = i - run + 1; end
      end else begin
        run = 0;
      end
    end
    tgt = (bl == 0) ? 0 : bs + ((g < bl / 2) ? g : bl / 2);
  endtask

  // one full pass, started by a reset-done edge (how 0) or a restart write
  task automatic run_pass(input int lo, len, g, how);
    int p0, s0, bs, bl, tgt, k;
    logic [31:0] rq;
    wr(OFS_GUARD, 32'(g));
    win_lo <= 8'(lo);
    win_len <= 8'(len);
    p0 = phase;
    s0 = step_cnt;
    if (how == 0) begin
      user_fifo_reset <= 1'b1; // retrain starts with a buffer reset
      rx_reset_done <= 4'h0;
      @(posedge hclk);
      user_fifo_reset <= 1'b0;
      repeat (10) @(posedge hclk);
      rx_reset_done <= 4'hF; // new rising edge restarts
    end else begin
      wr(OFS_CTRL, 32'h3);
    end
    k = 0;
    do begin @(posedge hclk); k++; end while (step_cnt == 16'(s0) && k < 300);
    if (k >= 300) begin n_errors++; wrap_up(); end
    do begin rd(OFS_STATUS, rq); k++; end while (rq[ST_DONE_BIT] !== 1'b1 && k < 9000);
    if (k >= 9000) begin n_errors++; wrap_up(); end
    model(p0, lo, len, g, bs, bl, tgt);
    chk(32'(step_cnt) - 32'(s0), 32'(SHIFT_COUNT_DEF + tgt));
    chk(32'(phase), 32'((p0 + tgt) % STEPS_PER_VCO));
    chk(32'(rq[ST_NOWIN_BIT]), 32'(bl == 0));
    chk(32'(rq[ST_STATE_LSB +: STATE_W]), 32'(S_DONE));
    rd(OFS_RESULT, rq);
    chk(32'(rq[23:16]), 32'(tgt));
    chk(32'(rq[15:8]), 32'(bl));
    if (bl > 0) chk(32'(rq[7:0]), 32'(bs));
    chk(32'(ovl_err), 32'h0);
    chk(32'(psgen_incdec), 32'(PS_INC));
  endtask

  // ----------------------------------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #5 hclk = ~hclk;
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_CTRL, q);
    chk(q, 32'h1);
    rd(OFS_GUARD, q);
    chk(q, {24'h0, GUARD_RST});
    rd(OFS_STEPS, q);
    chk(q, 32'(SHIFT_COUNT_DEF));
    wr(OFS_STEPS, 32'h0);
    rd(OFS_STEPS, q);
    chk(q, 32'(SHIFT_COUNT_DEF));
    rd(8'h14, q);
    chk(q, 32'h0);
    chk(32'(hresp), 32'(HRESP_OKAY));
    chk(32'(hreadyout), 32'h1);
    // one buffer reset after lock, seen one cycle later
    repeat (20) @(posedge hclk);
    user_fifo_reset <= 1'b1;
    @(posedge hclk);
    user_fifo_reset <= 1'b0;
    #1 chk(32'(rx_elastic_buffer_reset), 32'h1);
    @(posedge hclk);
    #1 chk(32'(rx_elastic_buffer_reset), 32'h0);
    @(posedge hclk);
    xfer(1'b1, OFS_CTRL, 32'h5, q);
    n = 0;
    repeat (4) begin #1 if (rx_elastic_buffer_reset === 1'b1) n++; @(posedge hclk); end
    chk(32'(n), 32'h1);
    rd(OFS_CTRL, q);
    chk(q, 32'h1);
    // three lanes ready is not enough to start
    rx_reset_done <= 4'h7;
    repeat (100) @(posedge hclk);
    chk(32'(step_cnt), 32'h0);
    for (int k = 0; k < 6; k++) begin
      if (k == 2) begin
        wr(OFS_CTRL, 32'h0); // disabled: edges start nothing
        n = step_cnt;
        rx_reset_done <= 4'h0;
        repeat (10) @(posedge hclk);
        rx_reset_done <= 4'hF;
        repeat (200) @(posedge hclk);
        chk(32'(step_cnt), 32'(n));
        wr(OFS_CTRL, 32'h1);
      end
      slow <= (k >= 3);
      run_pass($unsigned($random(seed)) % STEPS_PER_VCO,
               (k == 1) ? 0 : (k == 4) ? STEPS_PER_VCO : 3 + 2 * ($unsigned($random(seed)) % 8),
               $unsigned($random(seed)) % 11, k % 2);
    end
    wrap_up();
  end
endmodule // rx_lane_phase_deskew_fsm_test

`default_nettype wire
